//--- rtl/ifbw_pkg.sv
// Overview of operation
// R1: timer register: six enables, six flags
// R2: clear enable means flag never sets
// R3: timer A event sets bit 0
// R4: timer B event sets bit 1
// R5: converter enable bit 16, flag bit 0
// R6: comparator enable bit 17, flag bit 1
// R7: amplifier enable bit 16, flag bit 0
// R8: port group 1 pin enables, pin flags
// R9: port group 2 same layout
// R10: reset mode overflow resets the chip
// R11: clear bit restarts count from zero
// R12: sleep stops the watchdog entirely
// R13: idle overflow never resets the chip
// R14: prescale divides by 2 to 32768
// R15: action bit picks flag or reset
// R16: reset action locks until chip reset
// R17: counts only in operation after run
// R18: run bit locks until chip reset
// R19: count clock is oscillator over 256
// R20: global enable gates every request; the code gates only irq_req, chip_reset_req is not gated
// R21: live count readable in bits 30:16
// R22: writing 0 clears a flag
// R23: fixed group priority, 0 highest
// R24: enabled pending flag raises vector request
// R25: mask bytes always read zero
package ifbw_pkg;

  localparam int IFBW_AW = 20;
  localparam logic [19:0] IFBW_ADDR_TIM = 20'h40004;
  localparam logic [19:0] IFBW_ADDR_ADC = 20'h40008;
  localparam logic [19:0] IFBW_ADDR_ANA = 20'h4000C;
  localparam logic [19:0] IFBW_ADDR_PT1 = 20'h40010;
  localparam logic [19:0] IFBW_ADDR_PT2 = 20'h40014;
  localparam logic [19:0] IFBW_ADDR_GCTL = 20'h40018;
  localparam logic [19:0] IFBW_ADDR_DOG = 20'h40108;

  localparam int IFBW_EN_LSB = 16;
  localparam int IFBW_DOG_FLAG = 4;
  localparam int IFBW_WD_RUN = 4;
  localparam int IFBW_WD_CLR = 5;
  localparam int IFBW_WD_ACT = 6;
  localparam int IFBW_WD_CNT_LSB = 16;
  localparam int IFBW_WD_CNT_W = 15;
  localparam logic [2:0] IFBW_WD_PRE_RST = 3'h7;
  localparam int IFBW_LPO_DIV = 256;
  localparam int IFBW_GROUPS = 6;
  localparam int IFBW_GCTL_GIE = 0;
  localparam int IFBW_GCTL_GRP_LSB = 16;
  localparam int IFBW_GCTL_REQ = 19;
  localparam logic [31:0] IFBW_VEC_BASE = 32'h00000000;

  typedef struct packed {
    logic com;
    logic [4:0] tim;
    logic adc;
    logic [1:0] ana;
    logic [7:0] pt1;
    logic [7:0] pt2;
  } ifbw_events_t;

  typedef struct packed {
    logic [5:0] tim_en;
    logic [5:0] tim_flag;
    logic adc_en;
    logic adc_flag;
    logic [1:0] ana_en;
    logic [1:0] ana_flag;
    logic [7:0] pt1_en;
    logic [7:0] pt1_flag;
    logic [7:0] pt2_en;
    logic [7:0] pt2_flag;
    logic global_irq_enable;
    logic [2:0] dog_pre;
    logic dog_act;
    logic dog_run;
    logic [14:0] dog_cnt;
    logic [7:0] lpo_div;
    logic rst_req;
    logic irq_req;
    logic [2:0] irq_grp;
    logic [31:0] vec_addr;
    logic [31:0] rdata;
  } ifbw_state_t;

  localparam ifbw_state_t IFBW_STATE_RST =
    '{dog_pre: IFBW_WD_PRE_RST, default: '0};

endpackage

//--- rtl/ifbw_top.sv
`timescale 1ns/1ns
module ifbw_top
  import ifbw_pkg::*;
#(
  parameter int LPO_DIV = IFBW_LPO_DIV
)
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [IFBW_AW-1:0] addr,
  input wire logic [31:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [31:0] rd_data,
  input wire ifbw_events_t events,
  input wire logic low_power_osc,
  input wire logic sleep_mode,
  input wire logic idle_mode,
  output logic irq_req,
  output logic [2:0] irq_group,
  output logic [31:0] irq_vec_addr,
  output logic chip_reset_req
);

  generate
    if (LPO_DIV < 2 || LPO_DIV > 256)
    begin : g_bad_div
      $error("LPO_DIV must lie in 2..256");
    end
  endgenerate

  localparam logic [7:0] DIV_LAST = 8'(LPO_DIV - 1);

  ifbw_state_t s_reg;
  ifbw_state_t s_next;

  logic wr_tim;
  logic wr_adc;
  logic wr_ana;
  logic wr_pt1;
  logic wr_pt2;
  logic wr_gctl;
  logic wr_dog;
  logic dog_clear;
  logic dog_active;
  logic wclk_tick;
  logic [15:0] dog_lim;
  logic dog_ovf;
  logic [5:0] tim_ev;
  logic [5:0] grp_pend;
  logic [2:0] grp_sel;

  always_comb
  begin
    wr_tim = wr_en && addr == IFBW_ADDR_TIM;
    wr_adc = wr_en && addr == IFBW_ADDR_ADC;
    wr_ana = wr_en && addr == IFBW_ADDR_ANA;
    wr_pt1 = wr_en && addr == IFBW_ADDR_PT1;
    wr_pt2 = wr_en && addr == IFBW_ADDR_PT2;
    wr_gctl = wr_en && addr == IFBW_ADDR_GCTL;
    wr_dog = wr_en && addr == IFBW_ADDR_DOG;
    // R11: clear strobe
    dog_clear = wr_dog && wr_data[IFBW_WD_CLR];
    // R12: R17: counts only when run and awake
    dog_active = s_reg.dog_run && !sleep_mode;
    // R19: fixed oscillator divider
    wclk_tick = dog_active && low_power_osc && s_reg.lpo_div == DIV_LAST;
    // R14: limit is 2^(2*code+1) - 1
    dog_lim = (16'h0001 << {s_reg.dog_pre, 1'b1}) - 16'h0001;
    dog_ovf = wclk_tick && {1'b0, s_reg.dog_cnt} == dog_lim;
    // R15: flag only in timer behaviour
    tim_ev = {events.tim[4], dog_ovf && !s_reg.dog_act, events.tim[3:0]};
    // R24: groups 1 to 5 pend on any enabled flag, group 0 on the com event
    grp_pend[0] = events.com;
    grp_pend[1] = |(s_reg.tim_en & s_reg.tim_flag);
    grp_pend[2] = s_reg.adc_en && s_reg.adc_flag;
    grp_pend[3] = |(s_reg.ana_en & s_reg.ana_flag);
    grp_pend[4] = |(s_reg.pt1_en & s_reg.pt1_flag);
    grp_pend[5] = |(s_reg.pt2_en & s_reg.pt2_flag);
    // R23: lowest group number wins
    grp_sel = 3'h0;
    for (int i = IFBW_GROUPS - 1; i >= 0; i--)
    begin
      if (grp_pend[i])
      begin
        grp_sel = 3'(i);
      end
    end
  end

  always_comb
  begin
    s_next = s_reg;
    // R1: R22: enables written, flags only cleared by 0
    if (wr_tim)
    begin
      s_next.tim_en = wr_data[IFBW_EN_LSB +: 6];
      s_next.tim_flag = s_reg.tim_flag & wr_data[5:0];
    end
    // R5: converter enable and flag
    if (wr_adc)
    begin
      s_next.adc_en = wr_data[IFBW_EN_LSB];
      s_next.adc_flag = s_reg.adc_flag & wr_data[0];
    end
    // R6: R7: comparator bit 1, amplifier bit 0
    if (wr_ana)
    begin
      s_next.ana_en = wr_data[IFBW_EN_LSB +: 2];
      s_next.ana_flag = s_reg.ana_flag & wr_data[1:0];
    end
    // R8: port group 1 by pin number
    if (wr_pt1)
    begin
      s_next.pt1_en = wr_data[IFBW_EN_LSB +: 8];
      s_next.pt1_flag = s_reg.pt1_flag & wr_data[7:0];
    end
    // R9: port group 2 same layout
    if (wr_pt2)
    begin
      s_next.pt2_en = wr_data[IFBW_EN_LSB +: 8];
      s_next.pt2_flag = s_reg.pt2_flag & wr_data[7:0];
    end
    if (wr_gctl)
    begin
      s_next.global_irq_enable = wr_data[IFBW_GCTL_GIE];
    end
    // R2: R3: R4: events set only enabled flags, set beats clear
    s_next.tim_flag = s_next.tim_flag | (tim_ev & s_reg.tim_en);
    s_next.adc_flag = s_next.adc_flag | (events.adc & s_reg.adc_en);
    s_next.ana_flag = s_next.ana_flag | (events.ana & s_reg.ana_en);
    s_next.pt1_flag = s_next.pt1_flag | (events.pt1 & s_reg.pt1_en);
    s_next.pt2_flag = s_next.pt2_flag | (events.pt2 & s_reg.pt2_en);

    if (wr_dog)
    begin
      s_next.dog_pre = wr_data[2:0];
      // R16: reset action sticks
      s_next.dog_act = s_reg.dog_act | wr_data[IFBW_WD_ACT];
      // R18: run bit sticks
      s_next.dog_run = s_reg.dog_run | wr_data[IFBW_WD_RUN];
    end
    // R11: clear also restarts the fixed divider
    if (dog_clear)
    begin
      s_next.dog_cnt = '0;
      s_next.lpo_div = '0;
    end
    else if (dog_active && low_power_osc)
    begin
      s_next.lpo_div = wclk_tick ? 8'h00 : s_reg.lpo_div + 8'h01;
      if (wclk_tick)
      begin
        s_next.dog_cnt = dog_ovf ? 15'h0000 : s_reg.dog_cnt + 15'h0001;
      end
    end
    // R10: R13: reset only in reset mode and not idle
    s_next.rst_req = dog_ovf && s_reg.dog_act && !idle_mode;

    // R20: no interrupt request reaches the core without global enable
    s_next.irq_req = s_reg.global_irq_enable && |grp_pend;
    s_next.irq_grp = grp_sel;
    s_next.vec_addr = IFBW_VEC_BASE + {27'h0, grp_sel, 2'b00};

    // R25: mask bytes and unused bits read zero
    s_next.rdata = 32'h00000000;
    if (rd_en)
    begin
      case (addr)
        IFBW_ADDR_TIM:
          s_next.rdata = {10'h000, s_reg.tim_en, 10'h000, s_reg.tim_flag};
        IFBW_ADDR_ADC:
          s_next.rdata = {15'h0000, s_reg.adc_en, 15'h0000, s_reg.adc_flag};
        IFBW_ADDR_ANA:
          s_next.rdata = {14'h0000, s_reg.ana_en, 14'h0000, s_reg.ana_flag};
        IFBW_ADDR_PT1:
          s_next.rdata = {8'h00, s_reg.pt1_en, 8'h00, s_reg.pt1_flag};
        IFBW_ADDR_PT2:
          s_next.rdata = {8'h00, s_reg.pt2_en, 8'h00, s_reg.pt2_flag};
        IFBW_ADDR_GCTL:
          s_next.rdata = {12'h000, s_reg.irq_req, s_reg.irq_grp,
                          15'h0000, s_reg.global_irq_enable};
        // R21: live count, clear bit reads back zero
        IFBW_ADDR_DOG:
          s_next.rdata = {1'b0, s_reg.dog_cnt, 9'h000, s_reg.dog_act,
                          1'b0, s_reg.dog_run, 1'b0, s_reg.dog_pre};
        default:
          s_next.rdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      s_reg <= IFBW_STATE_RST;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  assign rd_data = s_reg.rdata;
  assign irq_req = s_reg.irq_req;
  assign irq_group = s_reg.irq_grp;
  assign irq_vec_addr = s_reg.vec_addr;
  assign chip_reset_req = s_reg.rst_req;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  // R2: flag rise needs enable
  a_flag_needs_enable: assert property ( // R2
    $rose(s_reg.tim_flag[1]) |-> $past(s_reg.tim_en[1]))
    else $error("timer b flag set while disabled");

  // R3: timer a event sets flag
  a_timer_a_set: assert property ( // R3
    events.tim[0] && s_reg.tim_en[0] |=> s_reg.tim_flag[0])
    else $error("timer a event lost");

  // R4: timer b event sets flag
  a_timer_b_set: assert property ( // R4
    events.tim[1] && s_reg.tim_en[1] |=> s_reg.tim_flag[1])
    else $error("timer b event lost");

  // R5: converter event sets flag
  a_adc_flag_set: assert property ( // R5
    events.adc && s_reg.adc_en |=> s_reg.adc_flag)
    else $error("converter flag not set");

  // R6: comparator flag follows event
  a_cmp_flag_set: assert property ( // R6
    events.ana[1] && s_reg.ana_en[1] |=> s_reg.ana_flag[1])
    else $error("comparator flag not set");

  // R7: amplifier flag follows event
  a_amp_flag_set: assert property ( // R7
    events.ana[0] && s_reg.ana_en[0] |=> s_reg.ana_flag[0])
    else $error("amplifier flag not set");

  // R8: port pin flag follows event
  a_port_pin_set: assert property ( // R8
    events.pt1[7] && s_reg.pt1_en[7] |=> s_reg.pt1_flag[7])
    else $error("port 1 pin 7 flag not set");

  // R9: second port same layout
  a_port2_pin_set: assert property ( // R9
    events.pt2[0] && s_reg.pt2_en[0] |=> s_reg.pt2_flag[0])
    else $error("port 2 pin 0 flag not set");

  // R10: reset follows overflow in reset mode
  a_dog_reset_out: assert property ( // R10
    dog_ovf && s_reg.dog_act && !idle_mode |=> chip_reset_req ##1
    !chip_reset_req || $past(dog_ovf))
    else $error("watchdog reset not raised");

  // R11: clear write zeroes the count
  a_dog_clear_zero: assert property ( // R11
    dog_clear |=> s_reg.dog_cnt == 15'h0000 && s_reg.lpo_div == 8'h00)
    else $error("watchdog clear ignored");

  // R12: sleep freezes the count
  a_sleep_frozen: assert property ( // R12
    sleep_mode && !dog_clear |=> $stable(s_reg.dog_cnt) && !chip_reset_req)
    else $error("watchdog moved in sleep");

  // R13: idle never resets
  a_idle_no_reset: assert property ( // R13
    idle_mode |=> !chip_reset_req)
    else $error("reset raised in idle");

  // R14: prescale reset value
  a_prescale_reset: assert property ( // R14
    $past(rst) |-> s_reg.dog_pre == IFBW_WD_PRE_RST)
    else $error("prescale reset value wrong");

  // R15: timer mode overflow sets dog flag
  a_dog_timer_flag: assert property ( // R15
    dog_ovf && !s_reg.dog_act && s_reg.tim_en[IFBW_DOG_FLAG]
    |=> s_reg.tim_flag[IFBW_DOG_FLAG] && !chip_reset_req)
    else $error("timer mode overflow mishandled");

  // R16: action lock
  a_action_lock: assert property ( // R16
    s_reg.dog_act |=> s_reg.dog_act)
    else $error("reset action unlocked");

  // R18: run lock
  a_run_lock: assert property ( // R18
    s_reg.dog_run |=> s_reg.dog_run[*2])
    else $error("run bit cleared");

  // R17: no tick before run
  a_count_needs_run: assert property ( // R17
    !s_reg.dog_run |-> !wclk_tick)
    else $error("watchdog ticked before run");

  // R19: count moves only on divider wrap
  a_count_on_tick: assert property ( // R19
    !wclk_tick && !dog_clear |=> $stable(s_reg.dog_cnt))
    else $error("watchdog count moved off tick");

  // R21: live count reads back
  a_count_readback: assert property ( // R21
    rd_en && addr == IFBW_ADDR_DOG
    |=> rd_data[30:16] == $past(s_reg.dog_cnt) && !rd_data[31])
    else $error("watchdog count readback wrong");

  // R24: vector follows group
  a_vector_addr: assert property ( // R24
    irq_req |-> irq_vec_addr == IFBW_VEC_BASE + {27'h0, irq_group, 2'b00})
    else $error("vector address wrong");

  // R20: no request without global enable
  a_global_gate: assert property ( // R20
    !s_reg.global_irq_enable |=> !irq_req)
    else $error("request without global enable");

  // R22: write of zero clears the flag
  a_flag_clear: assert property ( // R22
    wr_tim && !wr_data[0] && !(events.tim[0] && s_reg.tim_en[0])
    |=> !s_reg.tim_flag[0])
    else $error("flag clear ignored");

  // R23: group 0 always wins
  a_group_priority: assert property ( // R23
    s_reg.global_irq_enable && events.com |=> irq_req && irq_group == 3'h0)
    else $error("priority order broken");

  // R25: mask byte reads zero
  a_mask_read_zero: assert property ( // R25
    $past(rd_en) |-> rd_data[15:8] == 8'h00)
    else $error("mask byte nonzero");

  c_timer_irq: cover property (
    s_reg.global_irq_enable && events.tim[0] && s_reg.tim_en[0] ##2 irq_group == 3'h1);
  c_dog_reset: cover property (chip_reset_req);
  c_dog_timer: cover property (dog_ovf && !s_reg.dog_act);
  c_preempt: cover property (
    irq_req && irq_group == 3'h5 ##1 irq_req && irq_group == 3'h0);

endmodule

//--- verification/ifbw_src.sv
`timescale 1ns/1ns
module ifbw_src
  import ifbw_pkg::*;
(
  input wire logic core_clk,
  input wire logic go,
  input wire logic [15:0] n_pulse,
  input wire logic [1:0] gap,
  input wire logic ev_go,
  input wire ifbw_events_t ev_in,
  output logic low_power_osc,
  output ifbw_events_t events,
  output logic busy
);
  logic [15:0] left = 16'h0;
  logic [1:0] space = 2'h0;
  assign busy = (left != 16'h0);
  // a request held up re-fires each cycle, like a level source
  always @(posedge core_clk)
  begin
    events <= ev_go ? ev_in : '0;
    low_power_osc <= 1'b0;
    if (go)
    begin
      left <= n_pulse;
      space <= 2'h0;
    end
    else if (busy && space == gap)
    begin
      low_power_osc <= 1'b1;
      left <= left - 16'h1;
      space <= 2'h0;
    end
    else if (busy)
      space <= space + 2'h1;
  end
endmodule

//--- verification/tb.sv
`timescale 1ns/1ns
module tb
  import ifbw_pkg::*;
;
  localparam logic [19:0] RA [5] = '{IFBW_ADDR_TIM, IFBW_ADDR_ADC,
    IFBW_ADDR_ANA, IFBW_ADDR_PT1, IFBW_ADDR_PT2};
  localparam logic [31:0] EN [5] = '{32'h003F0000, 32'h00010000,
    32'h00030000, 32'h00FF0000, 32'h00FF0000};
  localparam logic [31:0] FL [5] = '{32'h0000002F, 32'h00000001,
    32'h00000003, 32'h000000FF, 32'h000000FF};
  localparam ifbw_events_t ALL_EV = '{com: 1'b0, tim: 5'h1F,
    adc: 1'b1, ana: 2'h3, pt1: 8'hFF, pt2: 8'hFF};
  localparam ifbw_events_t COM_EV = '{com: 1'b1, default: '0};
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic go = 1'b0;
  logic ev_go = 1'b0;
  logic sleep_mode = 1'b0;
  logic idle_mode = 1'b0;
  logic rd_del = 1'b0;
  logic [19:0] addr = 20'h0;
  logic [31:0] wr_data = 32'h0;
  logic [15:0] n_pulse = 16'h0;
  logic [1:0] gap = 2'h0;
  ifbw_events_t ev_in = '0;
  ifbw_events_t events;
  logic [31:0] rd_data, irq_vec_addr;
  logic low_power_osc, irq_req, chip_reset_req, busy;
  logic [2:0] irq_group;
  logic [7:0] en_r, ev_r;
  logic [31:0] exp_q [$];
  int miscompares = 0;
  int n_compared = 0;
  int n_rst = 0;
  int seed = 63230;

  always #50 core_clk = ~core_clk;

  ifbw_top #(.LPO_DIV(2)) u_ifbw_top (.core_clk(core_clk), .rst(rst),
    .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
    .rd_data(rd_data), .events(events), .low_power_osc(low_power_osc),
    .sleep_mode(sleep_mode), .idle_mode(idle_mode), .irq_req(irq_req),
    .irq_group(irq_group), .irq_vec_addr(irq_vec_addr),
    .chip_reset_req(chip_reset_req));
  ifbw_src u_ifbw_src (.core_clk(core_clk), .go(go), .n_pulse(n_pulse),
    .gap(gap), .ev_go(ev_go), .ev_in(ev_in),
    .low_power_osc(low_power_osc), .events(events), .busy(busy));

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task wr(input logic [19:0] a, input logic [31:0] d);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge core_clk);
    wr_en <= 1'b0;
    @(posedge core_clk);
  endtask

  // the expected word waits in the queue for the monitor
  task rd(input logic [19:0] a, input logic [31:0] e);
    addr <= a;
    rd_en <= 1'b1;
    exp_q.push_back(e);
    @(posedge core_clk);
    rd_en <= 1'b0;
    @(posedge core_clk);
  endtask

  task osc(input int n, input logic [1:0] g);
    int k;
    k = 0;
    n_pulse <= 16'(n);
    gap <= g;
    go <= 1'b1;
    @(posedge core_clk);
    go <= 1'b0;
    @(negedge core_clk);
    while (busy !== 1'b0 && k < 5000)
    begin
      @(negedge core_clk);
      k++;
    end
    if (k >= 5000)
    begin
      miscompares++;
      tally_and_finish();
    end
    repeat (4) @(posedge core_clk);
  endtask

  task ev(input ifbw_events_t e);
    ev_in <= e;
    ev_go <= 1'b1;
    @(posedge core_clk);
    ev_go <= 1'b0;
    repeat (3) @(posedge core_clk);
  endtask

  task irq_chk(input logic r, input logic [2:0] g);
    @(negedge core_clk);
    chk({31'h0, irq_req}, {31'h0, r});
    if (r)
    begin
      chk({29'h0, irq_group}, {29'h0, g});
      chk(irq_vec_addr, IFBW_VEC_BASE + {27'h0, g, 2'h0});
    end
    @(posedge core_clk);
  endtask

  always @(posedge core_clk) rd_del <= rd_en;

  always @(negedge core_clk)
  begin
    if (chip_reset_req === 1'b1)
      n_rst++;
    if (rd_del)
      chk(rd_data, exp_q.pop_front());
    else
      chk(rd_data, 32'h0);
  end

  initial
  begin
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    for (int i = 0; i < 5; i++)
      rd(RA[i], 32'h0);
    rd(IFBW_ADDR_DOG, 32'h00000007);
    rd(20'h40020, 32'h0);
    for (int i = 0; i < 5; i++)
    begin
      wr(RA[i], 32'hFFFFFFFF);
      rd(RA[i], EN[i]);
    end
    ev(ALL_EV);
    irq_chk(1'b0, 3'h0);
    for (int i = 0; i < 5; i++)
      rd(RA[i], EN[i] | FL[i]);
    wr(IFBW_ADDR_GCTL, 32'h00000001);
    rd(IFBW_ADDR_GCTL, 32'h00090001);
    ev_in <= COM_EV;
    ev_go <= 1'b1;
    repeat (3) @(posedge core_clk);
    irq_chk(1'b1, 3'h0);
    ev_go <= 1'b0;
    repeat (2) @(posedge core_clk);
    // cancel groups in turn, the next higher-numbered one takes over
    for (int i = 0; i < 5; i++)
    begin
      irq_chk(1'b1, 3'(i + 1));
      wr(RA[i], EN[i]);
    end
    irq_chk(1'b0, 3'h0);
    for (int k = 0; k < 6; k++)
    begin
      if (k == 4)
        continue;
      wr(IFBW_ADDR_TIM, 32'h1 << (16 + k));
      ev(ALL_EV);
      rd(IFBW_ADDR_TIM, (32'h1 << (16 + k)) | (32'h1 << k));
    end
    repeat (4)
    begin
      en_r = 8'($random(seed));
      ev_r = 8'($random(seed));
      wr(IFBW_ADDR_PT1, {8'h0, en_r, 16'h0});
      wr(IFBW_ADDR_PT2, {8'h0, ev_r, 16'h0});
      ev('{com: 1'b0, tim: 5'h0, adc: 1'b0, ana: 2'h0,
        pt1: ev_r, pt2: en_r});
      rd(IFBW_ADDR_PT1, {8'h0, en_r, 8'h0, en_r & ev_r});
      rd(IFBW_ADDR_PT2, {8'h0, ev_r, 8'h0, ev_r & en_r});
    end
    wr(IFBW_ADDR_GCTL, 32'h0);
    osc(6, 2'h0);
    rd(IFBW_ADDR_DOG, 32'h00000007);
    // one pulse short of overflow, then the last one
    for (int p = 0; p < 3; p++)
    begin
      wr(IFBW_ADDR_DOG, 32'h30 | p);
      wr(IFBW_ADDR_TIM, 32'h00100000);
      osc(2 * (1 << (2 * p + 1)) - 1, 2'(p));
      rd(IFBW_ADDR_TIM, 32'h00100000);
      osc(1, 2'h0);
      rd(IFBW_ADDR_TIM, 32'h00100010);
    end
    wr(IFBW_ADDR_DOG, 32'h00000037);
    osc(10, 2'h1);
    rd(IFBW_ADDR_DOG, 32'h00050017);
    sleep_mode <= 1'b1;
    osc(8, 2'h0);
    rd(IFBW_ADDR_DOG, 32'h00050017);
    sleep_mode <= 1'b0;
    wr(IFBW_ADDR_DOG, 32'h00000027);
    rd(IFBW_ADDR_DOG, 32'h00000017);
    idle_mode <= 1'b1;
    wr(IFBW_ADDR_DOG, 32'h00000070);
    osc(4, 2'h0);
    chk(32'(n_rst), 32'h0);
    wr(IFBW_ADDR_DOG, 32'h00000030);
    rd(IFBW_ADDR_DOG, 32'h00000050);
    idle_mode <= 1'b0;
    osc(4, 2'h2);
    chk(32'(n_rst), 32'h1);
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    rd(IFBW_ADDR_DOG, 32'h00000007);
    tally_and_finish();
  end
endmodule
